// file: inc/sqpt_pkg.sv
// Overview of operation
// - leading channel sets count direction
// - count every edge, four per cycle
// - sine/cosine keeps coarse cycle count
// - interpolate 2^n points, n 5..12
// - fine equals 2^n/360 times arctangent
// - position equals coarse times 2^n plus fine
// - no interpolation gives four counts per period
// - all feedback reported in equivalent counts
// - sine/cosine raises speed limit to 50M
// - separate input sets: encoder pins or sine/cosine samples
package sqpt_pkg;
    localparam int ADC_W = 16;
    localparam int PHASE_W = 12;
    localparam int CORDIC_STEPS = 12;
    localparam logic [PHASE_W-1:0] PHASE_HALF = 12'h800;
    localparam logic [3:0] INTERP_NONE = 4'h0;
    localparam logic [3:0] INTERP_MIN = 4'h5;
    localparam logic [3:0] INTERP_MAX = 4'hC;
    // no interpolation behaves like two bits: one count per quadrant
    localparam logic [3:0] INTERP_QUAD = 4'h2;
    localparam logic [25:0] SPEED_STD = 26'h14FB180;
    localparam logic [25:0] SPEED_SINCOS = 26'h2FAF080;

    typedef struct packed {
        logic signed [ADC_W-1:0] va;
        logic signed [ADC_W-1:0] vb;
    } sqpt_sample_t;

    typedef struct packed {
        logic dirUp;
        logic countStep;
        logic sinCosActive;
    } sqpt_status_t;

    typedef enum logic [1:0] {
        SQPT_IDLE = 2'b00,
        SQPT_RUN = 2'b01,
        SQPT_DONE = 2'b11
    } sqpt_state_t;
endpackage : sqpt_pkg

// file: core/sqpt_phase.sv
`timescale 1ns/1ps
// vectoring cordic: angle of (va, vb) as a fraction of one full cycle
module sqpt_phase (
    clk,
    resetn,
    sampleValid,
    sample,
    phaseValid,
    phase
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic sampleValid;
    input wire sqpt_pkg::sqpt_sample_t sample;
    output logic phaseValid;
    output logic [sqpt_pkg::PHASE_W-1:0] phase;

    localparam int XW = sqpt_pkg::ADC_W + 2;

    // atan(2^-i) scaled to 4096 per turn
    function automatic logic [sqpt_pkg::PHASE_W-1:0] atanStep(input logic [3:0] i);
        case (i)
            4'h0: atanStep = 12'h200;
            4'h1: atanStep = 12'h12E;
            4'h2: atanStep = 12'h0A0;
            4'h3: atanStep = 12'h051;
            4'h4: atanStep = 12'h029;
            4'h5: atanStep = 12'h014;
            4'h6: atanStep = 12'h00A;
            4'h7: atanStep = 12'h005;
            4'h8: atanStep = 12'h003;
            4'h9: atanStep = 12'h001;
            4'hA: atanStep = 12'h001;
            default: atanStep = 12'h000;
        endcase
    endfunction : atanStep

    sqpt_pkg::sqpt_state_t state_q;
    logic signed [XW-1:0] x_q;
    logic signed [XW-1:0] y_q;
    logic [sqpt_pkg::PHASE_W-1:0] z_q;
    logic [3:0] step_q;

    wire signed [XW-1:0] vaExt = XW'(sample.va);
    wire signed [XW-1:0] vbExt = XW'(sample.vb);
    // left half plane folded by half a turn so iterations converge
    wire fold = sample.va < 0;
    wire signed [XW-1:0] xShift = x_q >>> step_q;
    wire signed [XW-1:0] yShift = y_q >>> step_q;
    wire yNonNeg = y_q >= 0;
    wire lastStep = step_q == 4'(sqpt_pkg::CORDIC_STEPS - 1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= sqpt_pkg::SQPT_IDLE;
            x_q <= '0;
            y_q <= '0;
            z_q <= '0;
            step_q <= 4'h0;
        end else begin
            case (state_q)
                sqpt_pkg::SQPT_IDLE: begin
                    if (sampleValid) begin
                        x_q <= fold ? -vaExt : vaExt;
                        y_q <= fold ? -vbExt : vbExt;
                        z_q <= fold ? sqpt_pkg::PHASE_HALF : '0;
                        step_q <= 4'h0;
                        state_q <= sqpt_pkg::SQPT_RUN;
                    end
                end
                sqpt_pkg::SQPT_RUN: begin
                    x_q <= yNonNeg ? x_q + yShift : x_q - yShift;
                    y_q <= yNonNeg ? y_q - xShift : y_q + xShift;
                    z_q <= yNonNeg ? z_q + atanStep(step_q) : z_q - atanStep(step_q);
                    step_q <= step_q + 4'h1;
                    if (lastStep) begin
                        state_q <= sqpt_pkg::SQPT_DONE;
                    end
                end
                sqpt_pkg::SQPT_DONE: begin
                    state_q <= sqpt_pkg::SQPT_IDLE;
                end
                default: begin
                    state_q <= sqpt_pkg::SQPT_IDLE;
                end
            endcase
        end
    end

    assign phaseValid = state_q == sqpt_pkg::SQPT_DONE;
    assign phase = z_q;
endmodule : sqpt_phase

// file: core/sqpt_tracker.sv
`timescale 1ns/1ps
module sqpt_tracker #(
    parameter int POS_W = 48
) (
    clk,
    resetn,
    encA,
    encB,
    sinCosMode,
    interpolationExponentSetting,
    sampleValid,
    sample,
    position,
    status,
    speedLimit
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic encA;
    input wire logic encB;
    input wire logic sinCosMode;
    input wire logic [3:0] interpolationExponentSetting;
    input wire logic sampleValid;
    input wire sqpt_pkg::sqpt_sample_t sample;
    output logic signed [POS_W-1:0] position;
    output sqpt_pkg::sqpt_status_t status;
    output logic [25:0] speedLimit;

    // at 50M counts/s a 48-bit count lasts for weeks of one-way travel
    if (POS_W < 32 || POS_W > 64) begin : gChk
        $error("POS_W must be 32..64");
    end

    // +1, -1 or 0 from old and new quadrant code (gray order 00,01,11,10)
    function automatic logic [1:0] quadStep(input logic [1:0] oldAB, input logic [1:0] newAB);
        logic [3:0] t;
        t = {oldAB, newAB};
        case (t)
            4'b0001, 4'b0111, 4'b1110, 4'b1000: quadStep = 2'b01;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: quadStep = 2'b11;
            default: quadStep = 2'b00;
        endcase
    endfunction : quadStep

    // effective bits of resolution per cycle
    function automatic logic [3:0] effBits(input logic [3:0] setting);
        if (setting == sqpt_pkg::INTERP_NONE) begin
            effBits = sqpt_pkg::INTERP_QUAD;
        end else if (setting < sqpt_pkg::INTERP_MIN) begin
            effBits = sqpt_pkg::INTERP_MIN;
        end else if (setting > sqpt_pkg::INTERP_MAX) begin
            effBits = sqpt_pkg::INTERP_MAX;
        end else begin
            effBits = setting;
        end
    endfunction : effBits

    // pin synchronisers
    logic [1:0] syncA_q;
    logic [1:0] syncB_q;
    logic [1:0] quadPrev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= 2'b00;
            syncB_q <= 2'b00;
        end else begin
            syncA_q <= {syncA_q[0], encA};
            syncB_q <= {syncB_q[0], encB};
        end
    end

    wire [1:0] quadNow = {syncA_q[1], syncB_q[1]};
    // lead of b over a gives up; lead of a over b gives down
    wire [1:0] quadDelta = quadStep(quadPrev_q, quadNow);
    wire quadUp = quadDelta == 2'b01;
    wire quadDown = quadDelta == 2'b11;

    logic signed [POS_W-1:0] quadCount_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quadPrev_q <= 2'b00;
            quadCount_q <= '0;
        end else begin
            quadPrev_q <= quadNow;
            if (quadUp) begin
                quadCount_q <= quadCount_q + POS_W'(1);
            end else if (quadDown) begin
                quadCount_q <= quadCount_q - POS_W'(1);
            end
        end
    end

    // sine/cosine path takes its own sample inputs, not the encA/encB pins used by quadrature
    wire phaseValid;
    wire [sqpt_pkg::PHASE_W-1:0] phase;

    sqpt_phase uPhase (
        .clk(clk),
        .resetn(resetn),
        .sampleValid(sampleValid && sinCosMode),
        .sample(sample),
        .phaseValid(phaseValid),
        .phase(phase)
    );

    logic [1:0] quadrant_q;
    logic [sqpt_pkg::PHASE_W-1:0] phase_q;
    logic signed [POS_W-1:0] cycles_q;

    wire [1:0] newQuadrant = phase[sqpt_pkg::PHASE_W-1 -: 2];
    // quadrants from the arctangent itself keep coarse and fine consistent
    wire [1:0] phaseDelta = quadStep({quadrant_q[1], quadrant_q[1] ^ quadrant_q[0]},
        {newQuadrant[1], newQuadrant[1] ^ newQuadrant[0]});
    wire wrapUp = quadrant_q == 2'b11 && newQuadrant == 2'b00;
    wire wrapDown = quadrant_q == 2'b00 && newQuadrant == 2'b11;
    wire phaseUp = phaseValid && phaseDelta == 2'b01;
    wire phaseDown = phaseValid && phaseDelta == 2'b11;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quadrant_q <= 2'b00;
            phase_q <= '0;
            cycles_q <= '0;
        end else if (phaseValid) begin
            quadrant_q <= newQuadrant;
            phase_q <= phase;
            if (wrapUp) begin
                cycles_q <= cycles_q + POS_W'(1);
            end else if (wrapDown) begin
                cycles_q <= cycles_q - POS_W'(1);
            end
        end
    end

    // position = coarse * 2^n + fine, fine = 2^n/360 * atan(vb/va)
    wire [3:0] nBits = effBits(interpolationExponentSetting);
    wire [3:0] fineShift = 4'(sqpt_pkg::PHASE_W) - nBits;
    wire [sqpt_pkg::PHASE_W-1:0] fine = phase_q >> fineShift;
    wire signed [POS_W-1:0] coarseScaled = cycles_q <<< nBits;
    wire signed [POS_W-1:0] sinCosPos = coarseScaled + POS_W'(fine);
    // one count unit for both feedback types
    wire signed [POS_W-1:0] posNext = sinCosMode ? sinCosPos : quadCount_q;

    logic signed [POS_W-1:0] position_q;
    sqpt_pkg::sqpt_status_t status_q;
    logic [25:0] speedLimit_q;

    wire stepUp = sinCosMode ? phaseUp : quadUp;
    wire stepDown = sinCosMode ? phaseDown : quadDown;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            position_q <= '0;
            status_q <= '0;
            speedLimit_q <= sqpt_pkg::SPEED_STD;
        end else begin
            position_q <= posNext;
            status_q.countStep <= stepUp || stepDown;
            if (stepUp || stepDown) begin
                status_q.dirUp <= stepUp;
            end
            status_q.sinCosActive <= sinCosMode;
            speedLimit_q <= sinCosMode ? sqpt_pkg::SPEED_SINCOS : sqpt_pkg::SPEED_STD;
        end
    end

    assign position = position_q;
    assign status = status_q;
    assign speedLimit = speedLimit_q;
endmodule : sqpt_tracker

// file: test/sqpt_tracker_props.sv
`timescale 1ns/1ps
module sqpt_tracker_props #(
    parameter int POS_W = 48
) (
    clk,
    resetn,
    encA,
    encB,
    sinCosMode,
    interpolationExponentSetting,
    sampleValid,
    sample,
    position,
    status,
    speedLimit
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic encA;
    input wire logic encB;
    input wire logic sinCosMode;
    input wire logic [3:0] interpolationExponentSetting;
    input wire logic sampleValid;
    input wire sqpt_pkg::sqpt_sample_t sample;
    input wire logic signed [POS_W-1:0] position;
    input wire sqpt_pkg::sqpt_status_t status;
    input wire logic [25:0] speedLimit;
    logic [4:0] idleCnt_q;
    logic [4:0] idleCnt_d;
    // saturates so a long quiet spell never wraps back into the update window
    assign idleCnt_d = (sampleValid || !sinCosMode) ? 5'h00 : idleCnt_q + {4'h0, ~&idleCnt_q};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) idleCnt_q <= 5'h00;
        else idleCnt_q <= idleCnt_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_spd_sincos: assert property (sinCosMode |=> speedLimit == sqpt_pkg::SPEED_SINCOS)
        else $error("speed limit not raised in sine/cosine mode");
    a_spd_std: assert property (!sinCosMode |=> speedLimit == sqpt_pkg::SPEED_STD)
        else $error("speed limit not standard in quadrature mode");
    a_step_pulse: assert property (status.countStep |=> !status.countStep)
        else $error("count step longer than one cycle");
    // position lands one cycle after the step flag
    a_quad_unit: assert property (!$past(sinCosMode) && !$past(sinCosMode, 2)
        && $past(status.countStep)
        |-> position == $past(position) + 1 || position == $past(position) - 1)
        else $error("quadrature step not one count");
    a_quad_dir: assert property (!$past(sinCosMode) && !$past(sinCosMode, 2)
        && $past(status.countStep)
        |-> $past(status.dirUp) == (position == $past(position) + 1))
        else $error("direction flag disagrees with count");
    a_quad_quiet: assert property ((!sinCosMode && $stable({encA, encB}))[*5]
        |=> $stable(position))
        else $error("position moved with quiet channels");
    a_sc_hold: assert property (sinCosMode && idleCnt_q > 5'h13 |-> $stable(position))
        else $error("position moved without a sample");
    a_sc_timing: assert property (sinCosMode && $past(sinCosMode) && !$stable(position)
        |-> idleCnt_q <= 5'h03 || idleCnt_q inside {[5'h0E:5'h10]})
        else $error("interpolated position out of its update slot");
endmodule : sqpt_tracker_props

bind sqpt_tracker sqpt_tracker_props #(.POS_W(POS_W)) u_sqpt_tracker_props (
    .clk(clk), .resetn(resetn), .encA(encA), .encB(encB), .sinCosMode(sinCosMode),
    .interpolationExponentSetting(interpolationExponentSetting), .sampleValid(sampleValid),
    .sample(sample), .position(position), .status(status), .speedLimit(speedLimit));

// file: test/sqpt_enc_model.sv
`timescale 1ns/1ps
module sqpt_enc_model (
    clk,
    resetn,
    stepUp,
    stepDn,
    angleDeg,
    encA,
    encB,
    sample
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic stepUp;
    input wire logic stepDn;
    input wire logic [8:0] angleDeg;
    output logic encA;
    output logic encB;
    output sqpt_pkg::sqpt_sample_t sample;
    localparam real DEG = 3.14159265358979 / 180.0;
    logic [1:0] gray_q;
    // gray order 00,01,11,10 upward: one channel a quarter cycle ahead
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) gray_q <= 2'h0;
        else if (stepUp) gray_q <= {gray_q[0], ~gray_q[1]};
        else if (stepDn) gray_q <= {~gray_q[0], gray_q[1]};
    end
    // differential pair seen as its decoded level
    assign encA = gray_q[1];
    assign encB = gray_q[0];
    always_comb begin
        sample.va = 16'($rtoi(16000.0 * $cos(angleDeg * DEG)));
        sample.vb = 16'($rtoi(16000.0 * $sin(angleDeg * DEG)));
    end
endmodule : sqpt_enc_model

// file: test/test_sincos_quadrature_position_tracker.sv
`timescale 1ns/1ps
module test_sincos_quadrature_position_tracker;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic stepUp = 1'b0;
    logic stepDn = 1'b0;
    logic [8:0] angleDeg = 9'h032;
    logic sinCosMode = 1'b0;
    logic [3:0] setting = 4'h0;
    logic sampleValid = 1'b0;
    logic encA;
    logic encB;
    sqpt_pkg::sqpt_sample_t sample;
    logic signed [47:0] position;
    sqpt_pkg::sqpt_status_t status;
    logic [25:0] speedLimit;
    int errCount = 0;
    int checkCount = 0;
    always #25 clk = ~clk;
    sqpt_enc_model u_sqpt_enc_model (.clk(clk), .resetn(resetn), .stepUp(stepUp),
        .stepDn(stepDn), .angleDeg(angleDeg), .encA(encA), .encB(encB), .sample(sample));
    sqpt_tracker #(.POS_W(48)) u_sqpt_tracker (.clk(clk), .resetn(resetn), .encA(encA),
        .encB(encB), .sinCosMode(sinCosMode), .interpolationExponentSetting(setting),
        .sampleValid(sampleValid), .sample(sample), .position(position), .status(status),
        .speedLimit(speedLimit));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic step(input logic up);
        stepUp = up;
        stepDn = !up;
        tick(1);
        stepUp = 1'b0;
        stepDn = 1'b0;
        tick(5);
    endtask : step
    task automatic sendAngle(input logic [8:0] a, input logic [3:0] n);
        angleDeg = a;
        setting = n;
        sampleValid = 1'b1;
        tick(1);
        sampleValid = 1'b0;
        tick(20);
    endtask : sendAngle
    task automatic testQuadCount;
        repeat (4) step(1'b1);
        check(64'(position), 64'h4);
        check(64'(status.dirUp), 64'h1);
        repeat (6) step(1'b0);
        check(64'(position), 64'(-2));
        check(64'(status.dirUp), 64'h0);
    endtask : testQuadCount
    task automatic testSinCosTrack;
        sinCosMode = 1'b1;
        tick(2);
        check(64'(speedLimit), 64'(sqpt_pkg::SPEED_SINCOS));
        check(64'(status.sinCosActive), 64'h1);
        sendAngle(9'h032, 4'h0);
        sendAngle(9'h08C, 4'h0);
        sendAngle(9'h0E6, 4'h0);
        sendAngle(9'h140, 4'h0);
        check(64'(position), 64'h3);
        sendAngle(9'h19A, 4'h0);
        check(64'(position), 64'h4);
        // out-of-range settings fall back to the nearest supported exponent
        sendAngle(9'h19A, 4'h3);
        check(64'(position), 64'h24);
        sendAngle(9'h19A, 4'hF);
        check(64'(position >>> 4), 64'h123);
        // 50 degrees sits mid-bucket so angle error cannot move these fine values
        for (int n = 5; n <= 8; n++) begin
            sendAngle(9'h19A, 4'(n));
            check(64'(position), 64'((1 << n) + (568 >> (12 - n))));
        end
        step(1'b1);
        step(1'b1);
        check(64'(position), 64'h123);
    endtask : testSinCosTrack
    task automatic testModeShare;
        sinCosMode = 1'b0;
        tick(3);
        check(64'(position), 64'h0);
        check(64'(speedLimit), 64'(sqpt_pkg::SPEED_STD));
    endtask : testModeShare
    task automatic tallyAndFinish;
        if (errCount == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tallyAndFinish
    initial begin
        repeat (6) @(posedge clk);
        #2;
        check(64'(speedLimit), 64'(sqpt_pkg::SPEED_STD));
        resetn = 1'b1;
        tick(3);
        testQuadCount();
        testSinCosTrack();
        testModeShare();
        tallyAndFinish();
    end
    initial begin
        #250000;
        errCount++;
        tallyAndFinish();
    end
endmodule : test_sincos_quadrature_position_tracker
